// >>> design/cps_clock_ctrl.sv
// clock prescalers, timer source muxes and auxiliary clock routing
//
// Overview of operation
// R1: timer prescaler divides by 1,2,4,6,8,10,12,16 from low three control bits.
// R2: peripheral prescaler divides by 1,2,4,8 from control bits 4 and 3.
// R3: reset clears low five control bits; both prescalers divide by one.
// R4: tick enable drives the three 16-bit timers and the 8-bit watchdog.
// R5: modem and two-wire interface run from the peripheral enable.
// R6: peripheral registers change only on their own clock.
// R7: timer 1 source: tick, pin, code fetch event, peripheral.
// R8: timer 0 source: tick, pin, instruction event, peripheral.
// R9: after reset both timer sources select the tick clock.
// R10: pin-sourced timer counts even with the oscillator stopped.
// R11: timer 1 aux mode counts every code byte request.
// R12: timer 0 aux mode counts every executed instruction.
// R13: aux clock is tick when source bit is 0, peripheral when 1.
// R14: clock-output enable routes aux clock onto the output pin.
// R15: lockstep bit feeds aux clock to the CPU instruction request.
// R16: software picks aux period longer than the slowest instruction.
// R17: software keeps peripheral rate within spec, up to 12 MHz.
// R18: config bits 7:6 timer 1, 5:4 timer 0, 1 comparator, 0 osc off.
// R19: prescalers are wrap counters; a new factor applies at the next wrap.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module cps_clock_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins and cpu events
  input  wire logic        timer1_ext_input,
  input  wire logic        timer0_ext_input,
  input  wire logic        code_fetch_request,
  input  wire logic        instruction_request,
  // clock enables to peripherals, clock pin, cpu request and config bits
  output logic             tick_enable,
  output logic             periph_enable,
  output logic             timer1_count,
  output logic             timer0_count,
  output logic             timer1_count_async,
  output logic             timer0_count_async,
  output logic             clock_output_pin,
  output logic             cpu_instr_request,
  output logic             comparator_sel,
  output logic             oscillator_disable
);
  cps_pkg::cps_prescaler_control_type  prescaler_control_q;
  cps_pkg::cps_syscfg_type syscfg_q;
  logic [3:0] tick_cnt_q;
  logic [3:0] per_cnt_q;
  logic [3:0] tick_last_q;
  logic [3:0] per_last_q;
  logic       tick_en_q;
  logic       per_en_q;
  logic       aux_q;
  logic [1:0] t1_sync_q;
  logic [1:0] t0_sync_q;
  logic       t1_prev_q;
  logic       t0_prev_q;
  logic [1:0] cf_sync_q;
  logic [1:0] ir_sync_q;
  logic       cf_prev_q;
  logic       ir_prev_q;
  logic       t1_pin_rise;
  logic       t0_pin_rise;
  logic       cf_rise;
  logic       ir_rise;
  logic       acc;
  logic       wr_prescaler_control;
  logic       wr_syscfg;

  // apb: zero wait, byte lane 0 holds the 8-bit register
  assign acc       = psel && penable;
  assign wr_prescaler_control  = acc && pwrite && pstrb[0] && (paddr == cps_pkg::PRESCALER_CONTROL_ADDR);
  assign wr_syscfg = acc && pwrite && pstrb[0] && (paddr == cps_pkg::SYSCFG_ADDR);
  assign pready    = 1'b1;
  assign pslverr   = acc && (paddr != cps_pkg::PRESCALER_CONTROL_ADDR) &&
                     (paddr != cps_pkg::SYSCFG_ADDR) && (paddr != cps_pkg::STATUS_ADDR);

  // R3 control reset
  // upper bits undefined in hardware; zero chosen for determinism
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_control_q <= {cps_pkg::PRESCALER_CONTROL_UP_RST, cps_pkg::PRESCALER_CONTROL_LOW_RST};
    end else if (wr_prescaler_control) begin
      prescaler_control_q <= pwdata[7:0];
    end
  end

  // R9 sources default tick
  // R18 config layout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syscfg_q <= cps_pkg::SYSCFG_RST;
    end else if (wr_syscfg) begin
      syscfg_q <= {pwdata[7:4], 2'h0, pwdata[1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        cps_pkg::PRESCALER_CONTROL_ADDR:  prdata <= {24'h00_0000, prescaler_control_q};
        cps_pkg::SYSCFG_ADDR: prdata <= {24'h00_0000, syscfg_q};
        cps_pkg::STATUS_ADDR: prdata <= {16'h0000, tick_cnt_q, per_cnt_q,
                                         6'h00, per_en_q, tick_en_q};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

  // R1 tick divider
  // R19 factor latched at wrap, avoids runt periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q  <= cps_pkg::CNT_ZERO;
      tick_last_q <= cps_pkg::CNT_ZERO;
      tick_en_q   <= 1'b0;
    end else if (tick_cnt_q >= tick_last_q) begin
      tick_cnt_q  <= cps_pkg::CNT_ZERO;
      tick_last_q <= cps_pkg::cps_tick_last(prescaler_control_q.tick_div);
      tick_en_q   <= 1'b1;
    end else begin
      tick_cnt_q  <= tick_cnt_q + cps_pkg::CNT_ONE;
      tick_en_q   <= 1'b0;
    end
  end

  // R2 peripheral divider
  // R19 wrap reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q  <= cps_pkg::CNT_ZERO;
      per_last_q <= cps_pkg::CNT_ZERO;
      per_en_q   <= 1'b0;
    end else if (per_cnt_q >= per_last_q) begin
      per_cnt_q  <= cps_pkg::CNT_ZERO;
      per_last_q <= cps_pkg::cps_per_last(prescaler_control_q.per_div);
      per_en_q   <= 1'b1;
    end else begin
      per_cnt_q  <= per_cnt_q + cps_pkg::CNT_ONE;
      per_en_q   <= 1'b0;
    end
  end

  // synchronisers: second stage feeds edge detect only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_sync_q <= 2'h0;
      t0_sync_q <= 2'h0;
      t1_prev_q <= 1'b0;
      t0_prev_q <= 1'b0;
    end else begin
      t1_sync_q <= {t1_sync_q[0], timer1_ext_input};
      t0_sync_q <= {t0_sync_q[0], timer0_ext_input};
      t1_prev_q <= t1_sync_q[1];
      t0_prev_q <= t0_sync_q[1];
    end
  end

  // self-timed cpu is another domain: its requests are synchronised too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cf_sync_q <= 2'h0;
      ir_sync_q <= 2'h0;
      cf_prev_q <= 1'b0;
      ir_prev_q <= 1'b0;
    end else begin
      cf_sync_q <= {cf_sync_q[0], code_fetch_request};
      ir_sync_q <= {ir_sync_q[0], instruction_request};
      cf_prev_q <= cf_sync_q[1];
      ir_prev_q <= ir_sync_q[1];
    end
  end

  assign t1_pin_rise = t1_sync_q[1] && !t1_prev_q;
  assign t0_pin_rise = t0_sync_q[1] && !t0_prev_q;
  // R11 one count per fetch
  assign cf_rise     = cf_sync_q[1] && !cf_prev_q;
  // R12 one count per instruction
  assign ir_rise     = ir_sync_q[1] && !ir_prev_q;

  // R4 tick to timers and watchdog
  // R5 peripheral enable to modem and two-wire
  // R6 peripheral updates qualified by these enables
  assign tick_enable   = tick_en_q;
  assign periph_enable = per_en_q;

  // R7 timer 1 source
  always_comb begin
    case (syscfg_q.timer1_source_sel)
      cps_pkg::SRC_TICK: timer1_count = tick_en_q;
      cps_pkg::SRC_PIN:  timer1_count = t1_pin_rise;
      cps_pkg::SRC_AUX:  timer1_count = cf_rise;
      default:           timer1_count = per_en_q;
    endcase
  end

  // R8 timer 0 source
  always_comb begin
    case (syscfg_q.timer0_source_sel)
      cps_pkg::SRC_TICK: timer0_count = tick_en_q;
      cps_pkg::SRC_PIN:  timer0_count = t0_pin_rise;
      cps_pkg::SRC_AUX:  timer0_count = ir_rise;
      default:           timer0_count = per_en_q;
    endcase
  end

  // R10 raw pin path needs no oscillator; timer clocks on it directly
  assign timer1_count_async = (syscfg_q.timer1_source_sel == cps_pkg::SRC_PIN) &&
                              timer1_ext_input;
  assign timer0_count_async = (syscfg_q.timer0_source_sel == cps_pkg::SRC_PIN) &&
                              timer0_ext_input;

  // R13 aux source mux, registered pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_q <= 1'b0;
    end else begin
      aux_q <= prescaler_control_q.aux_clock_source_sel ? per_en_q : tick_en_q;
    end
  end

  // R14 clock output
  assign clock_output_pin  = prescaler_control_q.aux_clock_pin_enable && aux_q;
  // R15 lockstep request
  // R16 one instruction per pulse only if software period is long enough
  assign cpu_instr_request = prescaler_control_q.lockstep && aux_q;
  assign comparator_sel     = syscfg_q.comparator_sel;
  assign oscillator_disable = syscfg_q.oscillator_disable;

  // assertions
  tick_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> prescaler_control_q[4:0] == 5'h00) // R3
    else $error("control not cleared at reset");
  tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en_q && tick_last_q == 4'h1 |-> ##1 !tick_en_q ##1 tick_en_q) // R1
    else $error("tick divide by two wrong");
  per_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    per_en_q && per_last_q == 4'h7 |-> ##1 !per_en_q [*7] ##1 per_en_q) // R2
    else $error("peripheral divide by eight wrong");
  t1_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    syscfg_q.timer1_source_sel == cps_pkg::SRC_PER |-> timer1_count == per_en_q) // R7
    else $error("timer 1 source wrong");
  t0_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    syscfg_q.timer0_source_sel == cps_pkg::SRC_AUX |-> timer0_count == ir_rise) // R8
    else $error("timer 0 source wrong");
  aux_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    prescaler_control_q.aux_clock_source_sel && $stable(prescaler_control_q) |-> aux_q == $past(per_en_q)) // R13
    else $error("aux source wrong");
  clock_output_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    !prescaler_control_q.aux_clock_pin_enable |-> !clock_output_pin) // R14
    else $error("clock output leaks");
  lockstep_a: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_instr_request |-> prescaler_control_q.lockstep && aux_q) // R15
    else $error("lockstep request wrong");
  fetch_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cf_sync_q[1]) && syscfg_q.timer1_source_sel == cps_pkg::SRC_AUX
    |-> timer1_count) // R11
    else $error("fetch not counted");
  cover_div16_c: cover property (@(posedge pclk) tick_last_q == 4'hf && tick_en_q);
  cover_lock_c: cover property (@(posedge pclk) cpu_instr_request);
  cover_pin_c: cover property (@(posedge pclk) t1_pin_rise && timer1_count);
endmodule // cps_clock_ctrl

// >>> design/cps_pkg.sv
// package: constants and carriers for the clock prescaler select block
package cps_pkg;
  // register byte addresses (printed offsets not multiples of four: index * 4)
  localparam logic [7:0]  PRESCALER_CONTROL_INDEX   = 8'hf3;
  localparam logic [7:0]  SYSCFG_INDEX  = 8'hb4;
  localparam logic [11:0] PRESCALER_CONTROL_ADDR    = {2'h0, PRESCALER_CONTROL_INDEX, 2'h0};
  localparam logic [11:0] SYSCFG_ADDR   = {2'h0, SYSCFG_INDEX, 2'h0};
  localparam logic [11:0] STATUS_ADDR   = 12'h004;
  // reset values
  localparam logic [4:0]  PRESCALER_CONTROL_LOW_RST = 5'h00;
  localparam logic [2:0]  PRESCALER_CONTROL_UP_RST  = 3'h0;
  localparam logic [7:0]  SYSCFG_RST    = 8'h00;
  // timer source codes and counter constants
  localparam logic [1:0]  SRC_TICK      = 2'h0;
  localparam logic [1:0]  SRC_PIN       = 2'h1;
  localparam logic [1:0]  SRC_AUX       = 2'h2;
  localparam logic [1:0]  SRC_PER       = 2'h3;
  localparam logic [3:0]  CNT_ONE       = 4'h1;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;

  typedef struct packed {
    logic       aux_clock_pin_enable;
    logic       aux_clock_source_sel;
    logic       lockstep;
    logic [1:0] per_div;
    logic [2:0] tick_div;
  } cps_prescaler_control_type;

  typedef struct packed {
    logic [1:0] timer1_source_sel;
    logic [1:0] timer0_source_sel;
    logic [1:0] unused;
    logic       comparator_sel;
    logic       oscillator_disable;
  } cps_syscfg_type;

  // divider terminal count (divide minus one)
  function automatic logic [3:0] cps_tick_last(input logic [2:0] sel);
    case (sel)
      3'h0:    cps_tick_last = 4'h0;
      3'h1:    cps_tick_last = 4'h1;
      3'h2:    cps_tick_last = 4'h3;
      3'h3:    cps_tick_last = 4'h5;
      3'h4:    cps_tick_last = 4'h7;
      3'h5:    cps_tick_last = 4'h9;
      3'h6:    cps_tick_last = 4'hb;
      default: cps_tick_last = 4'hf;
    endcase
  endfunction

  function automatic logic [3:0] cps_per_last(input logic [1:0] sel);
    case (sel)
      2'h0:    cps_per_last = 4'h0;
      2'h1:    cps_per_last = 4'h1;
      2'h2:    cps_per_last = 4'h3;
      default: cps_per_last = 4'h7;
    endcase
  endfunction
endpackage

// >>> tb/cps_far_end.sv
// far-side model: cpu request events and timer pins
`timescale 1ns/1ps
module cps_far_end (
  // bench control
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic       mode,
  input  wire logic [3:0] n1,
  input  wire logic [3:0] n0,
  // lines toward the block
  output logic            code_fetch_request,
  output logic            instruction_request,
  output logic            timer1_ext_input,
  output logic            timer0_ext_input,
  output logic            busy
);
  logic l1, l0;
  int   hold;
  assign code_fetch_request  = !mode & l1;
  assign instruction_request = !mode & l0;
  assign timer1_ext_input    = mode & l1;
  assign timer0_ext_input    = mode & l0;
  initial begin
    l1 = 1'b0;
    l0 = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        for (int i = 0; i < 7; i++) begin
          // slow enough pacing
          // prompt or slow pacing, never under two cycles a level
          hold = 2 + $urandom % 4;
          l1 <= (i < n1);
          l0 <= (i < n0);
          repeat (hold) @(posedge pclk);
          l1 <= 1'b0;
          l0 <= 1'b0;
          repeat (hold) @(posedge pclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // cps_far_end

// >>> tb/testbench.sv
// testbench: apb driver, divider and mux checks against a bench model
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] PA = cps_pkg::PRESCALER_CONTROL_ADDR;
  localparam logic [11:0] SA = cps_pkg::SYSCFG_ADDR;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0]  pstrb, n1, n0;
  logic        go, mode, busy, t1p, t0p, fetch, instr, tick, per, t1c, t0c;
  logic        t1a, t0a, clk_out, cpu_req, cmp_sel, osc_off;
  logic [7:0]  prescaler_control_m, sys_m;
  int          n_fail, compares, c1, c0, p;
  int          tick_tab[8] = '{1, 2, 4, 6, 8, 10, 12, 16};
  int          per_tab[4] = '{1, 2, 4, 8};

  cps_clock_ctrl u_cps_clock_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer1_ext_input(t1p),
    .timer0_ext_input(t0p), .code_fetch_request(fetch), .instruction_request(instr),
    .tick_enable(tick), .periph_enable(per), .timer1_count(t1c), .timer0_count(t0c),
    .timer1_count_async(t1a), .timer0_count_async(t0a), .clock_output_pin(clk_out),
    .cpu_instr_request(cpu_req), .comparator_sel(cmp_sel), .oscillator_disable(osc_off));
  cps_far_end u_cps_far_end (.pclk(pclk), .go(go), .mode(mode), .n1(n1), .n0(n0),
    .code_fetch_request(fetch), .instruction_request(instr), .timer1_ext_input(t1p),
    .timer0_ext_input(t0p), .busy(busy));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_sig(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && s[0] && a == PA) prescaler_control_m = d[7:0];
    if (w && s[0] && a == SA) sys_m = d[7:0] & 8'hf3;
    chk_sig(err, a != PA && a != SA && a != cps_pkg::STATUS_ADDR);
  endtask

  // gap between the second and third pulse, so a new factor has wrapped in
  // sampled mid-cycle: registered pulses are settled there
  task automatic period(input logic w, output int q);
    for (int k = 0; k < 3; k++) begin
      q = 0;
      do begin
        @(negedge pclk);
        q++;
      end while ((w ? per : tick) !== 1'b1 && q < 40);
    end
  endtask

  // aux clock is registered: it shows last cycle's selected pulse
  task automatic watch(input int cyc);
    logic aux;
    logic aux_prev;
    @(negedge pclk);
    aux_prev = prescaler_control_m[6] ? per : tick;
    repeat (cyc) begin
      @(negedge pclk);
      aux = prescaler_control_m[6] ? per : tick;
      chk_sig(clk_out, prescaler_control_m[7] & aux_prev);
      chk_sig(cpu_req, prescaler_control_m[5] & aux_prev);
      aux_prev = aux;
      chk_sig(t1c, sys_m[7:6] == 2'h3 ? per : tick);
      chk_sig(t0c, sys_m[5:4] == 2'h3 ? per : tick);
      chk_sig(cmp_sel, sys_m[1]);
      chk_sig(osc_off, sys_m[0]);
    end
  endtask

  task automatic burst(input logic m);
    int n;
    mode <= m;
    n1 <= 4'(1 + $urandom % 6);
    n0 <= 4'(1 + $urandom % 6);
    go <= 1'b1;
    c1 = 0;
    c0 = 0;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 200);
    repeat (8) @(posedge pclk);
    chk_reg(c1, n1);
    chk_reg(c0, n0);
  endtask

  always @(negedge pclk) begin
    if (t1c === 1'b1) c1++;
    if (t0c === 1'b1) c0++;
    if (presetn === 1'b1 && sys_m[7:6] == 2'h1) chk_sig(t1a, t1p);
    if (presetn === 1'b1 && sys_m[5:4] == 2'h1) chk_sig(t0a, t0p);
  end

  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, go, mode} = 6'h00;
    {paddr, pwdata, pstrb, n1, n0} = 56'h0;
    {prescaler_control_m, sys_m, n_fail, compares} = 80'h0;
    void'($urandom(32'h4d48df6b));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PA, 32'h0, 4'hf);
    chk_reg(rd, 32'h0);
    apb(1'b0, SA, 32'h0, 4'hf);
    chk_reg(rd, 32'h0);
    apb(1'b1, 12'h100, 32'hff, 4'hf);
    apb(1'b0, 12'h100, 32'h0, 4'hf);
    chk_reg(rd, 32'h0);
    period(1'b0, p);
    chk_reg(p, 1);
    for (int d = 0; d < 8; d++) begin
      v = $urandom;
      apb(1'b1, PA, {24'h0, v[7:5], d[1:0], d[2:0]}, 4'hf);
      apb(1'b1, SA, {24'h0, v[8], v[8], v[9], v[9], v[3:0]}, 4'hf);
      apb(1'b0, PA, 32'h0, 4'hf);
      chk_reg(rd, prescaler_control_m);
      apb(1'b0, SA, 32'h0, 4'hf);
      chk_reg(rd, sys_m);
      period(1'b0, p);
      chk_reg(p, tick_tab[d]);
      period(1'b1, p);
      chk_reg(p, per_tab[d % 4]);
      watch(24);
    end
    apb(1'b1, PA, 32'h0, 4'he);
    apb(1'b0, PA, 32'h0, 4'hf);
    chk_reg(rd, prescaler_control_m);
    apb(1'b1, SA, 32'ha0, 4'hf);
    burst(1'b0);
    apb(1'b1, SA, 32'h50, 4'hf);
    burst(1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {prescaler_control_m, sys_m} = 16'h0;
    apb(1'b0, PA, 32'h0, 4'hf);
    chk_reg(rd, 32'h0);
    apb(1'b0, cps_pkg::STATUS_ADDR, 32'h0, 4'hf);
    chk_reg(rd, 32'h3);
    watch(8);
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    finish_test;
  end
endmodule // testbench
